/* ceag_pkg.sv */
// shared constants, types and the stand-in cipher transform of the access gate
package ceag_pkg;

    // --------
    // widths and sizes
    // --------
    localparam int DATA_W  = 32;
    localparam int SLOTS   = 4;
    localparam int SLOT_W  = 2;
    localparam int KWORDS  = 16;
    localparam int KIDX_W  = 4;
    localparam int KLEN_W  = 10;
    localparam int PIPE_W  = 2;
    localparam int HASH_W  = 256;
    localparam int BUF_DEPTH = 2;

    // --------
    // key sizes in bits
    // --------
    localparam logic [KLEN_W-1:0] AES_SHORT_BITS = 10'h080;
    localparam logic [KLEN_W-1:0] AES_LONG_BITS  = 10'h100;
    localparam logic [KLEN_W-1:0] TDES_BITS      = 10'h0c0;
    localparam logic [KLEN_W-1:0] HMAC_MIN_BITS  = 10'h070;
    localparam logic [KLEN_W-1:0] HMAC_MAX_BITS  = 10'h200;

    // --------
    // self-test vectors and reset values
    // --------
    localparam int          KAT_COUNT = 9;
    localparam logic [3:0]  KAT_LAST  = 4'h8;
    localparam logic [31:0] KAT_KEY   = 32'h5a3c_96e1;
    localparam logic [31:0] KAT_SEED  = 32'h0f1e_2d3c;
    localparam logic [31:0] KEY_RST   = 32'h0000_0000;
    localparam logic [KLEN_W-1:0] KLEN_RST = 10'h000;

    // --------
    // enumerations
    // --------
    typedef enum logic [3:0] {
        ALG_AES, ALG_TDES, ALG_SHA1, ALG_SHA256, ALG_HMAC1,
        ALG_HMAC256, ALG_CMAC, ALG_DES, ALG_AEAD
    } ceag_alg_e;

    typedef enum logic [2:0] {
        MODE_CBC, MODE_ECB, MODE_CTR, MODE_XTS, MODE_CCM, MODE_NONE
    } ceag_mode_e;

    typedef enum logic [2:0] {
        ERR_NONE, ERR_LOCKED, ERR_ROLE, ERR_NOTREADY,
        ERR_KEYSIZE, ERR_MODE, ERR_PIPE, ERR_AUTH
    } ceag_err_e;

    // --------
    // carriers
    // --------
    typedef struct packed {
        ceag_alg_e          alg;
        ceag_mode_e         mode;
        logic               dec;
        logic [SLOT_W-1:0]  slot;
        logic [PIPE_W-1:0]  pipe;
    } ceag_cmd_s;

    typedef struct packed {
        logic               officer_role;
        logic [SLOT_W-1:0]  slot;
        logic [KIDX_W-1:0]  idx;
        logic [KLEN_W-1:0]  len_bits;
        logic [DATA_W-1:0]  data;
    } ceag_keywr_s;

    typedef struct packed {
        logic [PIPE_W-1:0]  pipe;
        logic               last;
        logic [DATA_W-1:0]  data;
    } ceag_word_s;

    // stand-in for the cipher datapath: keyed, reversible, never identity
    function automatic logic [31:0] ceag_xform(input logic [31:0] key,
                                               input logic [31:0] din,
                                               input ceag_alg_e   alg,
                                               input logic        dec);
        logic [31:0] mix;
        logic [31:0] t;
        mix = {key[26:0], key[31:27]} ^ {28'h0000000, alg} ^ 32'h9e37_79b9;
        t   = din ^ mix;
        if (dec) begin
            t = {din[2:0], din[31:3]} ^ mix;
        end else begin
            t = {t[28:0], t[31:29]};
        end
        return t;
    endfunction : ceag_xform

endpackage : ceag_pkg

/* ceag_buf.sv */
// two-entry output buffer with valid and ready on both sides
module ceag_buf #(
    parameter int W     = 35,
    parameter int DEPTH = 2
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rstn,
    // filling side
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    // draining side
    output logic              out_valid,
    output logic [W-1:0]      out_data,
    input  wire logic         out_ready
);
    localparam int PW = (DEPTH > 2) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
        $error("ceag_buf: DEPTH must be a power of two of at least 2");
    end

    logic [W-1:0]  mem_r [DEPTH];
    logic [PW-1:0] wr_ptr_r;
    logic [PW-1:0] rd_ptr_r;
    logic [PW:0]   cnt_r;
    logic [PW:0]   cnt_nxt;
    logic          push;
    logic          pop;

    assign push     = in_valid & in_ready;
    assign pop      = out_valid & out_ready;
    assign out_data = mem_r[rd_ptr_r];

    always_comb begin
        cnt_nxt = cnt_r;
        if (push && !pop) begin
            cnt_nxt = cnt_r + 1'b1;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r     <= '0;
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            cnt_r     <= cnt_nxt;
            in_ready  <= (cnt_nxt != (PW+1)'(DEPTH));
            out_valid <= (cnt_nxt != '0);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

endmodule : ceag_buf

/* ceag_selftest.sv */
// power-up known-answer test sequencer with lock on mismatch
module ceag_selftest (
    // clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // synchronised fault injection
    input  wire logic corrupt,
    // result
    output logic      testing,
    output logic      passed,
    output logic      locked
);
    import ceag_pkg::*;

    typedef enum logic [1:0] {KT_RUN, KT_PASS, KT_LOCK} ceag_kt_e;

    ceag_kt_e    state_r;
    logic [3:0]  idx_r;
    logic [31:0] pt;
    logic [31:0] ct;
    logic [31:0] back;
    logic        mismatch;

    // one round trip per algorithm slot in the enumeration
    always_comb begin
        pt       = KAT_SEED + {28'h0000000, idx_r};
        ct       = ceag_xform(KAT_KEY, pt, ceag_alg_e'(idx_r), 1'b0)
                   ^ {31'h00000000, corrupt};
        back     = ceag_xform(KAT_KEY, ct, ceag_alg_e'(idx_r), 1'b1);
        mismatch = (back != pt);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= KT_RUN;
            idx_r   <= 4'h0;
            testing <= 1'b1;
            passed  <= 1'b0;
            locked  <= 1'b0;
        end else begin
            case (state_r)
                KT_RUN: begin
                    if (mismatch) begin
                        state_r <= KT_LOCK;
                        testing <= 1'b0;
                        locked  <= 1'b1;
                    end else if (idx_r == KAT_LAST) begin
                        state_r <= KT_PASS;
                        testing <= 1'b0;
                        passed  <= 1'b1;
                    end else begin
                        idx_r <= idx_r + 4'h1;
                    end
                end
                KT_PASS: state_r <= KT_PASS;
                KT_LOCK: state_r <= KT_LOCK;
                default: state_r <= KT_LOCK;
            endcase
        end
    end

endmodule : ceag_selftest

/* ceag_access_gate.sv */
// access gate shell of the crypto engine
module ceag_access_gate #(
    parameter int KEY_SLOTS = ceag_pkg::SLOTS
) (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rstn,
    // command request
    input  wire logic                      cmd_valid,
    input  wire ceag_pkg::ceag_cmd_s       cmd,
    output logic                           cmd_ready,
    // key load
    input  wire logic                      key_valid,
    input  wire ceag_pkg::ceag_keywr_s     key,
    // data input pipe
    input  wire logic                      in_valid,
    input  wire ceag_pkg::ceag_word_s      in_word,
    output logic                           in_ready,
    // data output pipe
    output logic                           out_valid,
    output ceag_pkg::ceag_word_s           out_word,
    input  wire logic                      out_ready,
    // read probe
    input  wire logic                      rd_valid,
    input  wire logic                      rd_secret,
    output logic                           rd_ack,
    output logic [ceag_pkg::DATA_W-1:0]    rd_data,
    // image key check
    input  wire logic                      auth_valid,
    input  wire logic [ceag_pkg::HASH_W-1:0] pubkey_hash,
    input  wire logic [ceag_pkg::HASH_W-1:0] otp_hash,
    output logic                           sig_go,
    // self-test fault pin
    input  wire logic                      kat_corrupt,
    // status
    output logic                           st_testing,
    output logic                           st_passed,
    output logic                           st_locked,
    output logic                           st_nonapproved,
    output ceag_pkg::ceag_err_e            err_code,
    output logic                           err_pulse
);
    import ceag_pkg::*;

    if (KEY_SLOTS < 1 || KEY_SLOTS > (1 << SLOT_W)) begin : g_chk
        $error("ceag_access_gate: bad KEY_SLOTS");
    end

    // --------
    // self-test
    // --------
    logic corrupt_s1_r;
    logic corrupt_s2_r;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            corrupt_s1_r <= 1'b0;
            corrupt_s2_r <= 1'b0;
        end else begin
            corrupt_s1_r <= kat_corrupt;
            corrupt_s2_r <= corrupt_s1_r;
        end
    end

    ceag_selftest u_kat (
        .clk     (clk),
        .rstn    (rstn),
        .corrupt (corrupt_s2_r),
        .testing (st_testing),
        .passed  (st_passed),
        .locked  (st_locked)
    );

    // --------
    // key store
    // --------
    logic [DATA_W-1:0] key_mem_r [KEY_SLOTS][KWORDS];
    logic [KLEN_W-1:0] key_len_r [KEY_SLOTS];
    logic              key_ok;
    ceag_err_e         key_err;

    always_comb begin
        key_err = ERR_NONE;
        if (st_locked) begin
            key_err = ERR_LOCKED;
        end else if (!st_passed) begin
            key_err = ERR_NOTREADY;
        end else if (!key.officer_role) begin
            key_err = ERR_ROLE;
        end else if (32'(key.slot) >= KEY_SLOTS) begin
            key_err = ERR_KEYSIZE;
        end
        key_ok = key_valid && (key_err == ERR_NONE);
    end

    // keys only enter here and only leave into the transform
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int s = 0; s < KEY_SLOTS; s++) begin
                key_len_r[s] <= KLEN_RST;
                for (int w = 0; w < KWORDS; w++) begin
                    key_mem_r[s][w] <= KEY_RST;
                end
            end
        end else if (key_ok) begin
            key_mem_r[key.slot][key.idx] <= key.data;
            key_len_r[key.slot]          <= key.len_bits;
        end
    end

    // --------
    // command check
    // --------
    logic [KLEN_W-1:0] klen;
    ceag_err_e         cmd_err;
    logic              cmd_na;
    logic              cmd_take;

    always_comb begin
        cmd_err = ERR_NONE;
        cmd_na  = 1'b0;
        klen    = (32'(cmd.slot) < KEY_SLOTS) ? key_len_r[cmd.slot] : KLEN_RST;
        case (cmd.alg)
            ALG_AES, ALG_CMAC: begin
                if (klen != AES_SHORT_BITS && klen != AES_LONG_BITS) begin
                    cmd_err = ERR_KEYSIZE;
                end else if (cmd.alg == ALG_AES && cmd.mode == MODE_NONE) begin
                    cmd_err = ERR_MODE;
                end
            end
            ALG_TDES: begin
                if (klen != TDES_BITS) begin
                    cmd_err = ERR_KEYSIZE;
                end else if (cmd.mode != MODE_CBC && cmd.mode != MODE_ECB) begin
                    cmd_err = ERR_MODE;
                end
            end
            ALG_HMAC1, ALG_HMAC256: begin
                if (klen > HMAC_MAX_BITS) begin
                    cmd_err = ERR_KEYSIZE;
                end else if (klen < HMAC_MIN_BITS) begin
                    cmd_na = 1'b1;
                end
            end
            ALG_DES, ALG_AEAD: cmd_na = 1'b1;
            ALG_SHA1, ALG_SHA256: cmd_err = ERR_NONE;
            default: cmd_err = ERR_MODE;
        endcase
        if (32'(cmd.slot) >= KEY_SLOTS) begin
            cmd_err = ERR_KEYSIZE;
        end
    end

    assign cmd_take = cmd_valid & cmd_ready;

    // --------
    // session
    // --------
    typedef enum logic {SES_IDLE, SES_RUN} ceag_ses_e;

    ceag_ses_e         ses_r;
    ceag_alg_e         ses_alg_r;
    logic              ses_dec_r;
    logic [SLOT_W-1:0] ses_slot_r;
    logic [PIPE_W-1:0] ses_pipe_r;
    logic [KIDX_W-1:0] widx_r;
    logic              in_take;
    logic              pipe_ok;
    logic              ses_end;

    assign in_take = in_valid & in_ready;
    assign pipe_ok = (in_word.pipe == ses_pipe_r);
    assign ses_end = in_take & pipe_ok & in_word.last;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ses_r          <= SES_IDLE;
            ses_alg_r      <= ALG_AES;
            ses_dec_r      <= 1'b0;
            ses_slot_r     <= '0;
            ses_pipe_r     <= '0;
            st_nonapproved <= 1'b0;
        end else begin
            case (ses_r)
                SES_IDLE: begin
                    if (cmd_take && cmd_err == ERR_NONE) begin
                        ses_r          <= SES_RUN;
                        ses_alg_r      <= cmd.alg;
                        ses_dec_r      <= cmd.dec;
                        ses_slot_r     <= cmd.slot;
                        ses_pipe_r     <= cmd.pipe;
                        st_nonapproved <= cmd_na;
                    end
                end
                SES_RUN: begin
                    if (ses_end) begin
                        ses_r          <= SES_IDLE;
                        st_nonapproved <= 1'b0;
                    end
                end
                default: ses_r <= SES_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            widx_r <= '0;
        end else if (cmd_take) begin
            widx_r <= '0;
        end else if (in_take && pipe_ok) begin
            widx_r <= widx_r + 1'b1;
        end
    end

    // --------
    // datapath stage and output buffer
    // --------
    ceag_word_s stage_r;
    logic       stage_v_r;
    logic       stage_v_nxt;
    logic       buf_ready;
    logic       drain;

    assign drain = stage_v_r & buf_ready;

    always_comb begin
        stage_v_nxt = stage_v_r;
        if (in_take && pipe_ok) begin
            stage_v_nxt = 1'b1;
        end else if (drain) begin
            stage_v_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stage_v_r <= 1'b0;
            stage_r   <= '0;
        end else begin
            stage_v_r <= stage_v_nxt;
            if (in_take && pipe_ok) begin
                stage_r.pipe <= ses_pipe_r;
                stage_r.last <= in_word.last;
                stage_r.data <= ceag_xform(key_mem_r[ses_slot_r][widx_r], in_word.data,
                                           ses_alg_r, ses_dec_r);
            end
        end
    end

    // in_ready only in a passed, unlocked session with a free stage; cmd_ready only when passed, unlocked and idle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            in_ready  <= 1'b0;
            cmd_ready <= 1'b0;
        end else begin
            in_ready  <= st_passed && !st_locked && !stage_v_nxt
                         && (ses_r == SES_RUN) && !ses_end && !in_take;
            cmd_ready <= st_passed && !st_locked
                         && (ses_r == SES_IDLE) && !cmd_take;
        end
    end

    ceag_buf #(
        .W     ($bits(ceag_word_s)),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .clk       (clk),
        .rstn      (rstn),
        .in_valid  (stage_v_r),
        .in_data   (stage_r),
        .in_ready  (buf_ready),
        .out_valid (out_valid),
        .out_data  (out_word),
        .out_ready (out_ready)
    );

    // --------
    // read probe and image key check
    // --------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_ack  <= 1'b0;
            rd_data <= '0;
        end else begin
            rd_ack  <= rd_valid;
            if (rd_valid && rd_secret) begin
                rd_data <= '0;
            end else if (rd_valid) begin
                rd_data <= {28'h0000000, st_nonapproved, st_locked,
                            st_passed, st_testing};
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sig_go <= 1'b0;
        end else begin
            sig_go <= auth_valid && st_passed && (pubkey_hash == otp_hash);
        end
    end

    // --------
    // error report, codes only
    // --------
    ceag_err_e err_nxt;

    always_comb begin
        err_nxt = ERR_NONE;
        if (key_valid && key_err != ERR_NONE) begin
            err_nxt = key_err;
        end else if (cmd_take && cmd_err != ERR_NONE) begin
            err_nxt = cmd_err;
        end else if (in_take && !pipe_ok) begin
            err_nxt = ERR_PIPE;
        end else if (auth_valid && (!st_passed || pubkey_hash != otp_hash)) begin
            err_nxt = ERR_AUTH;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            err_code  <= ERR_NONE;
            err_pulse <= 1'b0;
        end else begin
            err_pulse <= (err_nxt != ERR_NONE);
            if (err_nxt != ERR_NONE) begin
                err_code <= err_nxt;
            end
        end
    end

endmodule : ceag_access_gate

/* ceag_assertions.sv */
// concurrent checks on the access gate ports
module ceag_chk (
    // clock and reset
    input wire logic                          clk,
    input wire logic                          rstn,
    // watched ports
    input wire logic                          cmd_ready,
    input wire logic                          in_valid,
    input wire logic                          in_ready,
    input wire logic                          out_valid,
    input wire ceag_pkg::ceag_word_s          out_word,
    input wire logic                          out_ready,
    input wire logic                          rd_valid,
    input wire logic                          rd_secret,
    input wire logic                          rd_ack,
    input wire logic [ceag_pkg::DATA_W-1:0]   rd_data,
    input wire logic                          auth_valid,
    input wire logic [ceag_pkg::HASH_W-1:0]   pubkey_hash,
    input wire logic [ceag_pkg::HASH_W-1:0]   otp_hash,
    input wire logic                          sig_go,
    input wire logic                          st_testing,
    input wire logic                          st_passed,
    input wire logic                          st_locked,
    input wire logic                          st_nonapproved
);
    import ceag_pkg::*;
    logic match_r;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) match_r <= 1'b0;
        else match_r <= auth_valid && (pubkey_hash == otp_hash);
    end
    AST_SECRET_ZERO: assert property (rd_valid && rd_secret |=> rd_ack && rd_data == '0)
        else $error("secret read");
    AST_RD_UPPER: assert property (rd_valid && !rd_secret |=> rd_ack && rd_data[31:4] == '0)
        else $error("status bits");
    AST_CMD_GATED: assert property (cmd_ready |-> st_passed && !st_locked && !st_nonapproved)
        else $error("cmd gate");
    AST_IN_GATED: assert property (in_ready |-> st_passed)
        else $error("in gate");
    AST_LOCK_HOLD: assert property (st_locked |=> st_locked && !st_passed && !st_testing)
        else $error("lock hold");
    AST_LOCK_DEAD: assert property (st_locked |-> !cmd_ready && !in_ready && !sig_go)
        else $error("lock serve");
    AST_TESTS_END: assert property (st_testing |-> ##[0:12] (st_passed || st_locked))
        else $error("test end");
    AST_OUT_HOLD: assert property (out_valid && !out_ready |=> out_valid && $stable(out_word))
        else $error("out hold");
    AST_IN_PACE: assert property (in_valid && in_ready |=> !in_ready)
        else $error("in pace");
    AST_SIG_GO: assert property (sig_go == (match_r && $past(st_passed)))
        else $error("sig go");
endmodule : ceag_chk
bind ceag_access_gate ceag_chk i_ceag_chk (.*);

/* ceag_sink.sv */
// dma master side that drains the output pipe, stalling on request
module ceag_sink (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rstn,
    // output pipe
    input  wire logic                 stall,
    input  wire logic                 out_valid,
    input  wire ceag_pkg::ceag_word_s out_word,
    output logic                      out_ready,
    // capture
    output int                        got,
    output logic [31:0]               last_data
);
    import ceag_pkg::*;
    assign out_ready = !stall;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            got <= 0;
            last_data <= 32'h0;
        end else if (out_valid && out_ready) begin
            got <= got + 1;
            last_data <= out_word.data;
        end
    end
endmodule : ceag_sink

/* tb_crypto_engine_access_gate.sv */
// self-checking bench of the access gate
module tb_crypto_engine_access_gate;
    import ceag_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rstn, cmd_valid, key_valid, in_valid, rd_valid, rd_secret, auth_valid, stall;
    logic kat_corrupt, cmd_ready, in_ready, out_valid, out_ready, rd_ack, sig_go, err_pulse;
    logic st_testing, st_passed, st_locked, st_nonapproved;
    logic [31:0] rd_data, last_data;
    logic [HASH_W-1:0] pubkey_hash, otp_hash;
    ceag_cmd_s cmd;
    ceag_keywr_s key;
    ceag_word_s in_word, out_word;
    ceag_err_e err_code;
    int got, bad_count, compares;
    localparam logic [20:0] TBL [13] = '{
        {ALG_AES, MODE_CTR, 10'h080, ERR_NONE, 1'b0}, {ALG_AES, MODE_CBC, 10'h100, ERR_NONE, 1'b0},
        {ALG_AES, MODE_XTS, 10'h100, ERR_NONE, 1'b0}, {ALG_AES, MODE_CCM, 10'h080, ERR_NONE, 1'b0},
        {ALG_AES, MODE_NONE, 10'h080, ERR_MODE, 1'b0}, {ALG_AES, MODE_ECB, 10'h0c0, ERR_KEYSIZE, 1'b0},
        {ALG_TDES, MODE_CBC, 10'h0c0, ERR_NONE, 1'b0}, {ALG_TDES, MODE_CTR, 10'h0c0, ERR_MODE, 1'b0},
        {ALG_HMAC256, MODE_NONE, 10'h200, ERR_NONE, 1'b0},
        {ALG_HMAC1, MODE_NONE, 10'h201, ERR_KEYSIZE, 1'b0},
        {ALG_HMAC256, MODE_NONE, 10'h070, ERR_NONE, 1'b0},
        {ALG_HMAC1, MODE_NONE, 10'h06f, ERR_NONE, 1'b1}, {ALG_DES, MODE_ECB, 10'h040, ERR_NONE, 1'b1}};
    ceag_access_gate i_ceag_access_gate (.*);
    ceag_sink i_ceag_sink (.*);
    function automatic logic [31:0] xf(logic [31:0] k, logic [31:0] d, logic [3:0] a);
        logic [31:0] t;
        t = d ^ {k[26:0], k[31:27]} ^ {28'h0, a} ^ 32'h9e37_79b9;
        return {t[28:0], t[31:29]};
    endfunction : xf
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic tk(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tk
    task automatic hs(bit s);
        int n;
        logic r;
        n = 0;
        do begin
            #1;
            r = s ? in_ready : cmd_ready;
            @(posedge clk);
            n++;
        end while (r !== 1'b1 && n < 200);
        if (r !== 1'b1) chk("ready", 1, 0);
    endtask : hs
    task automatic rst;
        @(posedge clk);
        rstn <= 1'b0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
    endtask : rst
    task automatic kw(logic r, logic [9:0] len, logic [31:0] d);
        @(posedge clk);
        key_valid <= 1'b1;
        key <= {r, 2'h0, 4'h0, len, d};
        @(posedge clk);
        key_valid <= 1'b0;
    endtask : kw
    task automatic cm(ceag_alg_e a, ceag_mode_e m);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd <= {a, m, 1'b0, 2'h0, 2'h1};
        hs(0);
        cmd_valid <= 1'b0;
    endtask : cm
    task automatic dw(logic [1:0] p, logic l, logic [31:0] d);
        @(posedge clk);
        in_valid <= 1'b1;
        in_word <= {p, l, d};
        hs(1);
        in_valid <= 1'b0;
    endtask : dw
    task automatic t_probe(logic s, logic m);
        @(posedge clk);
        rd_valid <= 1'b1;
        rd_secret <= s;
        auth_valid <= 1'b1;
        otp_hash <= {8{32'h1234_abcd}} ^ HASH_W'(!m);
        @(posedge clk);
        rd_valid <= 1'b0;
        auth_valid <= 1'b0;
        #1;
        chk("rd_data", s ? 32'h0 : 32'h2, rd_data);
        chk("sig_go", m, sig_go);
        if (!m) chk("auth_err", ERR_AUTH, err_code);
    endtask : t_probe
    task automatic t_table;
        logic [3:0] a;
        logic [2:0] m, e;
        logic [9:0] ln;
        logic na;
        foreach (TBL[i]) begin
            {a, m, ln, e, na} = TBL[i];
            kw(1'b1, ln, 32'h1000_0000 + i);
            cm(ceag_alg_e'(a), ceag_mode_e'(m));
            #1;
            chk("err_pulse", e != ERR_NONE, err_pulse);
            if (e != ERR_NONE) chk("err_code", e, err_code);
            else begin
                chk("nonapproved", na, st_nonapproved);
                dw(2'h1, 1'b1, 32'h0bad_cafe);
                tk(6);
                chk("out", xf(32'h1000_0000 + i, 32'h0bad_cafe, a), last_data);
                chk("na_end", 0, st_nonapproved);
            end
        end
    endtask : t_table
    task automatic t_stream;
        int g0;
        g0 = got;
        kw(1'b0, 10'h080, 32'h0);
        tk(1);
        chk("role", ERR_ROLE, err_code);
        kw(1'b1, 10'h080, 32'h7777_0001);
        cm(ALG_AES, MODE_ECB);
        dw(2'h2, 1'b0, 32'h55);
        tk(1);
        chk("pipe", ERR_PIPE, err_code);
        fork
            begin
                stall <= 1'b1;
                tk(30);
                chk("full", 0, in_ready);
                chk("held", g0, got);
                @(posedge clk);
                stall <= 1'b0;
            end
            for (int k = 0; k < 4; k++) dw(2'h1, k == 3, 32'h100 + k);
        join
        tk(8);
        chk("count", g0 + 4, got);
        chk("last", xf(32'h0, 32'h103, ALG_AES), last_data);
    endtask : t_stream
    task automatic t_boot(logic bad);
        kat_corrupt <= bad;
        rst();
        tk(6);
        chk("testing", !bad, st_testing);
        chk("early", bad, st_passed | st_locked);
        tk(6);
        chk("passed", !bad, st_passed);
        chk("locked", bad, st_locked);
    endtask : t_boot
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : complete_run
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (30000) @(posedge clk);
        bad_count++;
        complete_run();
    end
    initial begin
        {rstn, cmd_valid, key_valid, in_valid, rd_valid, rd_secret, auth_valid} = '0;
        {stall, kat_corrupt, cmd, key, in_word} = '0;
        pubkey_hash = {8{32'h1234_abcd}};
        otp_hash = '0;
        t_boot(1'b0);
        t_probe(1'b1, 1'b1);
        t_probe(1'b0, 1'b0);
        t_table();
        t_stream();
        t_boot(1'b1);
        kw(1'b1, 10'h080, 32'h1);
        tk(1);
        chk("lock_key", ERR_LOCKED, err_code);
        t_boot(1'b0);
        cm(ALG_AES, MODE_ECB);
        tk(1);
        chk("zeroized", ERR_KEYSIZE, err_code);
        complete_run();
    end
endmodule : tb_crypto_engine_access_gate
